// ### design/fbm_host.sv
`timescale 1ns/1ps
`include "fbm_params.svh"
// Summary of operation
// - program and erase only via command writes
// - high voltage on bit nine reads identity
// - protection read at offset two, bit zero
// - protect all sectors before unprotecting; the host has no protect step, I_UNPROT_HV_EN drives O_FL_RESET_HV only while O_FL_RESET_N is high
// - reset low powers down; wait 50ns
// - byte mode uses top pin as address
module fbm_host
   import fbm_pkg::*;
(
   // clock and reset
   input wire logic I_CORE_CLK,
   input wire logic I_SYS_RST,
   // user request side
   input wire fbm_req_t I_REQ,
   input wire logic I_REQ_VALID,
   output logic O_REQ_READY,
   output logic [15:0] O_RD_DATA,
   output logic O_RD_VALID,
   // mode straps
   input wire logic I_BYTE_MODE,
   input wire logic I_ID_HV_EN,
   input wire logic I_UNPROT_HV_EN,
   // flash pins
   output logic [17:0] O_FL_ADDR,
   output logic O_FL_ADDR_LOW,
   output logic O_FL_CS_N,
   output logic O_FL_OE_N,
   output logic O_FL_WE_N,
   output logic O_FL_RESET_N,
   output logic O_FL_A9_HV,
   output logic O_FL_RESET_HV,
   output logic O_FL_BYTE_N,
   input wire logic [15:0] I_FL_DQ,
   output logic [15:0] O_FL_DQ,
   output logic [15:0] O_FL_DQ_OE_N
);
   ////////////////////////////////////////////////////////////////////////
   fbm_state_t state;
   fbm_state_t next_state;
   logic [7:0] cnt;
   logic [7:0] next_cnt;
   fbm_op_t op;
   logic [15:0] dq_s1;
   logic [15:0] dq_s2;
   logic [15:0] dq_s3;
   logic [15:0] dq_stable;
   logic rd_done;
   logic cnt_zero;
   logic req_take;
   logic id_like;
   logic [7:0] access_cyc;
   logic [7:0] pulse_cyc;
   logic [7:0] hold_cyc;
   logic [7:0] recover_cyc;

   // constant cycle counts
   assign access_cyc = 8'(`FBM_ACCESS_CYC);
   assign pulse_cyc = 8'(`FBM_WR_PULSE_CYC);
   assign hold_cyc = 8'(`FBM_RST_HOLD_CYC);
   assign recover_cyc = 8'(`FBM_RST_RECOVER_CYC);

   // decode
   assign cnt_zero = (cnt == 8'h00);
   assign O_REQ_READY = (state == FBM_IDLE);
   assign req_take = O_REQ_READY && I_REQ_VALID;
   assign id_like = (op == FBM_OP_ID_READ) || (op == FBM_OP_PROT_READ);
   // pins settle two samples before data is trusted
   assign rd_done = (state == FBM_RD) && cnt_zero;

   ////////////////////////////////////////////////////////////////////////
   // next state logic
   always_comb
   begin
      next_state = state;
      next_cnt = cnt_zero ? 8'h00 : 8'(cnt - 8'h01);
      unique case (state)
         FBM_IDLE:
         begin
            if (req_take)
            begin
               unique case (I_REQ.op)
                  FBM_OP_WRITE:
                  begin
                     next_state = FBM_WR_SETUP;
                     next_cnt = 8'h01;
                  end
                  FBM_OP_RESET:
                  begin
                     next_state = FBM_RST_LOW;
                     next_cnt = hold_cyc;
                  end
                  default:
                  begin
                     // access time plus three-stage sampling
                     next_state = FBM_RD;
                     next_cnt = 8'(access_cyc + 8'h03);
                  end
               endcase
            end
         end
         FBM_RD:
            if (cnt_zero)
               next_state = FBM_IDLE;
         FBM_WR_SETUP:
            if (cnt_zero)
            begin
               next_state = FBM_WR_PULSE;
               next_cnt = pulse_cyc;
            end
         FBM_WR_PULSE:
            if (cnt_zero)
            begin
               next_state = FBM_WR_HOLD;
               next_cnt = 8'h01;
            end
         FBM_WR_HOLD:
            if (cnt_zero)
               next_state = FBM_IDLE;
         FBM_RST_LOW:
            if (cnt_zero)
            begin
               next_state = FBM_RST_WAIT;
               next_cnt = recover_cyc;
            end
         FBM_RST_WAIT:
            if (cnt_zero)
               next_state = FBM_IDLE;
      endcase
   end

   // state registers
   always_ff @(posedge I_CORE_CLK)
   begin
      if (I_SYS_RST)
      begin
         state <= FBM_IDLE;
         cnt <= 8'h00;
      end
      else
      begin
         state <= next_state;
         cnt <= next_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // latch request fields for pins
   always_ff @(posedge I_CORE_CLK)
   begin
      if (I_SYS_RST)
      begin
         op <= FBM_OP_READ;
         O_FL_ADDR <= 18'h00000;
         O_FL_ADDR_LOW <= 1'b0;
         O_FL_DQ <= 16'h0000;
      end
      else if (req_take)
      begin
         op <= I_REQ.op;
         O_FL_ADDR_LOW <= I_REQ.addr[0];
         O_FL_DQ <= I_REQ.data;
         if (I_REQ.op == FBM_OP_PROT_READ)
            O_FL_ADDR <= {I_REQ.addr[17:12], 10'h000, 2'h0} | `FBM_ID_PROT_OFS;
         else if (I_REQ.op == FBM_OP_ID_READ)
            O_FL_ADDR <= I_REQ.addr[0] ? `FBM_ID_DEVICE_OFS : `FBM_ID_MAKER_OFS;
         else
            O_FL_ADDR <= I_REQ.addr;
      end
   end

   always_ff @(posedge I_CORE_CLK)
   begin
      if (I_SYS_RST)
      begin
         O_FL_CS_N <= 1'b1;
         O_FL_OE_N <= 1'b1;
         O_FL_WE_N <= 1'b1;
         O_FL_RESET_N <= 1'b1;
         O_FL_A9_HV <= 1'b0;
      end
      else
      begin
         O_FL_CS_N <= !(next_state == FBM_RD || next_state == FBM_WR_SETUP ||
                        next_state == FBM_WR_PULSE || next_state == FBM_WR_HOLD);
         O_FL_OE_N <= !(next_state == FBM_RD);
         O_FL_WE_N <= !(next_state == FBM_WR_PULSE);
         O_FL_RESET_N <= !(next_state == FBM_RST_LOW);
         O_FL_A9_HV <= (next_state == FBM_RD) && I_ID_HV_EN &&
                       (req_take ? (I_REQ.op == FBM_OP_ID_READ ||
                                    I_REQ.op == FBM_OP_PROT_READ) : id_like);
      end
   end

   assign O_FL_RESET_HV = I_UNPROT_HV_EN && O_FL_RESET_N;
   assign O_FL_BYTE_N = !I_BYTE_MODE;

   // data drive during writes only, low enable drives
   genvar g;
   generate
      for (g = 0; g < 16; g++)
      begin : g_dq
         assign O_FL_DQ_OE_N[g] = !((state == FBM_WR_SETUP || state == FBM_WR_PULSE ||
                                     state == FBM_WR_HOLD) && !(I_BYTE_MODE && g > 7));
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // three-stage sampling of data pins
   always_ff @(posedge I_CORE_CLK)
   begin
      if (I_SYS_RST)
      begin
         dq_s1 <= 16'h0000;
         dq_s2 <= 16'h0000;
         dq_s3 <= 16'h0000;
         dq_stable <= 16'h0000;
      end
      else
      begin
         dq_s1 <= I_FL_DQ;
         dq_s2 <= dq_s1;
         dq_s3 <= dq_s2;
         if (dq_s2 == dq_s3)
            dq_stable <= dq_s3;
      end
   end

   // read data capture
   always_ff @(posedge I_CORE_CLK)
   begin
      if (I_SYS_RST)
      begin
         O_RD_DATA <= 16'h0000;
         O_RD_VALID <= 1'b0;
      end
      else
      begin
         O_RD_VALID <= rd_done;
         if (rd_done)
            // protection bit on lowest data pin
            O_RD_DATA <= (op == FBM_OP_PROT_READ) ? {15'h0000, dq_stable[0]} :
                         (I_BYTE_MODE ? {8'h00, dq_stable[7:0]} : dq_stable);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // assertions
   a_we_needs_cs: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      !O_FL_WE_N |-> !O_FL_CS_N && O_FL_OE_N)
      else $error("write strobe outside select");
   a_we_width: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      $fell(O_FL_WE_N) |-> !O_FL_WE_N [*3])
      else $error("write strobe too short");
   a_data_hold: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      $rose(O_FL_WE_N) |-> $stable(O_FL_DQ) && !O_FL_DQ_OE_N[0])
      else $error("data not held at strobe rise");
   a_no_drive_read: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      !O_FL_OE_N |-> O_FL_DQ_OE_N == 16'hFFFF)
      else $error("host drives during read");
   a_rst_recover: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      $rose(O_FL_RESET_N) |-> O_FL_OE_N [*3])
      else $error("read too soon after reset");
   a_rst_idle: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      !O_FL_RESET_N |-> O_FL_CS_N && O_FL_WE_N)
      else $error("bus active during reset");
   a_hv_read_only: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      // high voltage only on id reads
      O_FL_A9_HV |-> !O_FL_OE_N && O_FL_WE_N)
      else $error("high voltage outside id read");
   a_addr_stable: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      !O_FL_CS_N && !$rose(O_FL_CS_N) && $past(!O_FL_CS_N) |-> $stable(O_FL_ADDR))
      else $error("address moved during access");
   a_rd_valid: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      $fell(O_FL_OE_N) |-> ##[5:12] O_RD_VALID)
      else $error("read answer missing");
   c_read: cover property (@(posedge I_CORE_CLK) O_RD_VALID && op == FBM_OP_READ);
   c_write: cover property (@(posedge I_CORE_CLK) $rose(O_FL_WE_N));
   c_prot: cover property (@(posedge I_CORE_CLK) O_RD_VALID && op == FBM_OP_PROT_READ);
   c_reset: cover property (@(posedge I_CORE_CLK) $rose(O_FL_RESET_N));
endmodule

// ### design/fbm_params.svh
`ifndef FBM_PARAMS_SVH
`define FBM_PARAMS_SVH
// bus widths
`define FBM_ADDR_W 18
`define FBM_DATA_W 16
// timing figures in ns and derived cycle counts at 50 MHz
`define FBM_CLK_MHZ 50
`define FBM_ACCESS_NS 120
`define FBM_ACCESS_CYC ((`FBM_ACCESS_NS * `FBM_CLK_MHZ + 999) / 1000)
`define FBM_WR_PULSE_NS 60
`define FBM_WR_PULSE_CYC ((`FBM_WR_PULSE_NS * `FBM_CLK_MHZ + 999) / 1000)
`define FBM_RST_RECOVER_NS 50
`define FBM_RST_RECOVER_CYC ((`FBM_RST_RECOVER_NS * `FBM_CLK_MHZ + 999) / 1000)
`define FBM_RST_HOLD_NS 500
`define FBM_RST_HOLD_CYC ((`FBM_RST_HOLD_NS * `FBM_CLK_MHZ + 999) / 1000)
// identification address offsets
`define FBM_ID_MAKER_OFS 18'h00000
`define FBM_ID_DEVICE_OFS 18'h00001
`define FBM_ID_PROT_OFS 18'h00002
`endif

// ### design/fbm_pkg.sv
package fbm_pkg;
   // host request operations
   typedef enum logic [2:0] {
      FBM_OP_READ,
      FBM_OP_WRITE,
      FBM_OP_ID_READ,
      FBM_OP_PROT_READ,
      FBM_OP_RESET
   } fbm_op_t;
   // one host request
   typedef struct packed {
      fbm_op_t op;
      logic [17:0] addr;
      logic [15:0] data;
   } fbm_req_t;
   // controller states
   typedef enum logic [2:0] {
      FBM_IDLE,
      FBM_RD,
      FBM_WR_SETUP,
      FBM_WR_PULSE,
      FBM_WR_HOLD,
      FBM_RST_LOW,
      FBM_RST_WAIT
   } fbm_state_t;
endpackage

// ### verif/fbm_flash_model.sv
`timescale 1ns/1ps
module fbm_flash_model
   import fbm_pkg::*;
#(
   parameter int ACC_NS = 100,
   parameter logic [15:0] MAKER_ID = 16'h00C3, // arbitrary value
   parameter logic [15:0] DEV_ID = 16'h5A17 // arbitrary value
)
(
   // host pins
   input wire logic [17:0] i_addr,
   input wire logic i_cs_n,
   input wire logic i_oe_n,
   input wire logic i_we_n,
   input wire logic i_reset_n,
   input wire logic i_a9_hv,
   input wire logic i_reset_hv,
   input wire logic [15:0] i_dq,
   // data out and recovery faults
   output logic [15:0] o_dq,
   output int o_viol
);
   logic [15:0] mem [logic [17:0]];
   logic [17:0] wa;
   logic [15:0] hold = 16'h0000;
   logic [15:0] val;
   realtime t_we = 0;
   realtime t_rst = 0;
   // writes finish at once, so deselect is standby
   wire rd_en = !i_cs_n && !i_oe_n && i_we_n && i_reset_n;
   wire wr_act = !i_cs_n && !i_we_n && i_oe_n && i_reset_n;
   wire prot = (i_addr[17:15] == 3'h7);
   ////////////////////////////////////////////////////////////////
   // array, identity or protection data
   always @*
   begin
      val = mem.exists(i_addr) ? mem[i_addr] : 16'hFFFF;
      if (i_a9_hv && i_addr[1])
         val = {15'h0000, prot};
      else if (i_a9_hv)
         val = i_addr[0] ? DEV_ID : MAKER_ID;
   end
   // undriven pins show the inverse of the last value
   always @(negedge rd_en)
      hold = ~o_dq;
   // address change gives new data after access time
   assign #(ACC_NS) o_dq = rd_en ? val : hold;
   ////////////////////////////////////////////////////////////////
   // address taken on the later falling edge
   always @(posedge wr_act)
   begin
      wa = i_addr;
      t_we = $realtime;
   end
   // data on first rising edge, short pulses dropped
   always @(negedge wr_act)
      if ($realtime - t_we > 5.0 && (wa[17:15] != 3'h7 || i_reset_hv))
         mem[wa] = i_dq;
   // read too soon after reset release
   initial o_viol = 0;
   always @(posedge i_reset_n)
      t_rst = $realtime;
   always @(posedge rd_en)
      if (t_rst > 0 && $realtime - t_rst < 50.0)
         o_viol++;
endmodule

// ### verif/flash_bus_mode_control_tb_top.sv
`timescale 1ns/1ps
`include "fbm_params.svh"
module flash_bus_mode_control_tb_top;
   import fbm_pkg::*;
   localparam logic [15:0] MAKER_ID = 16'h00C3; // arbitrary value
   localparam logic [15:0] DEV_ID = 16'h5A17; // arbitrary value
   logic clk = 1'b0;
   logic rst = 1'b1;
   fbm_req_t req = '0;
   logic req_valid = 1'b0, byte_mode = 1'b0, id_hv = 1'b0, unprot_hv = 1'b0;
   logic req_ready, rd_valid, cs_n, oe_n, we_n, reset_n, a9_hv, reset_hv, byte_n;
   logic [15:0] rd_data, dq_h, dq_d, dq_oe_n;
   logic [17:0] fl_addr;
   logic addr_low;
   int miscompares = 0, num_checks = 0, seed = 32648, viol;
   logic [15:0] shadow [logic [17:0]];
   // pin level from both drivers
   wire [15:0] pin = (dq_h & dq_oe_n) | (dq_d & ~dq_oe_n);
   ////////////////////////////////////////////////////////////////
   fbm_host i_dut (.I_CORE_CLK(clk), .I_SYS_RST(rst), .I_REQ(req), .I_REQ_VALID(req_valid),
      .O_REQ_READY(req_ready), .O_RD_DATA(rd_data), .O_RD_VALID(rd_valid),
      .I_BYTE_MODE(byte_mode), .I_ID_HV_EN(id_hv), .I_UNPROT_HV_EN(unprot_hv),
      .O_FL_ADDR(fl_addr), .O_FL_ADDR_LOW(addr_low), .O_FL_CS_N(cs_n), .O_FL_OE_N(oe_n),
      .O_FL_WE_N(we_n), .O_FL_RESET_N(reset_n), .O_FL_A9_HV(a9_hv),
      .O_FL_RESET_HV(reset_hv), .O_FL_BYTE_N(byte_n), .I_FL_DQ(pin), .O_FL_DQ(dq_d),
      .O_FL_DQ_OE_N(dq_oe_n));
   fbm_flash_model #(.ACC_NS(100), .MAKER_ID(MAKER_ID), .DEV_ID(DEV_ID)) i_flash (
      .i_addr(fl_addr), .i_cs_n(cs_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_reset_n(reset_n),
      .i_a9_hv(a9_hv), .i_reset_hv(reset_hv), .i_dq(pin), .o_dq(dq_h), .o_viol(viol));
   initial
      forever #10 clk = ~clk;
   ////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // bounded wait for one flag at falling edges
   task automatic wait_hi(input int which, output int n);
      n = 0;
      while ((which ? rd_valid : req_ready) !== 1'b1 && n < 100)
      begin
         @(negedge clk);
         n++;
         if (reset_n === 1'b0)
            num_checks = num_checks + 0;
      end
      if (n >= 100)
      begin
         miscompares++;
         report_and_stop();
      end
   endtask
   task automatic issue(input fbm_op_t op, input logic [17:0] a, input logic [15:0] d);
      int n;
      wait_hi(0, n);
      req = '{op, a, d};
      req_valid = 1'b1;
      @(negedge clk);
      req_valid = 1'b0;
   endtask
   task automatic rd(input fbm_op_t op, input logic [17:0] a, output logic [15:0] q);
      int n;
      issue(op, a, 16'h0000);
      wait_hi(1, n);
      q = rd_data;
   endtask
   task automatic wr(input logic [17:0] a, input logic [15:0] d);
      issue(FBM_OP_WRITE, a, d);
      if (a[17:15] != 3'h7 || unprot_hv)
         shadow[a] = d;
   endtask
   function automatic logic [15:0] exp_rd(input logic [17:0] a);
      return shadow.exists(a) ? shadow[a] : 16'hFFFF;
   endfunction
   ////////////////////////////////////////////////////////////////
   // host never drives data while the gate is low
   always @(negedge clk)
      if (!rst && oe_n === 1'b0)
         chk(dq_oe_n, 16'hFFFF, "contention");
   // write strobe only with gate high
   always @(negedge clk)
      if (!rst && we_n === 1'b0)
         chk(oe_n, 1'b1, "write gate");
   // main sequence
   initial
   begin
      logic [15:0] q;
      logic [15:0] e;
      logic [17:0] a;
      int cnt;
      repeat (6) @(negedge clk);
      rst = 1'b0;
      wr(18'h00000, 16'hA5C3);
      repeat (12)
      begin
         a = 18'({$random(seed)} % 32'h38000);
         wr(a, 16'($random(seed)));
         rd(FBM_OP_READ, a, q);
         chk(q, exp_rd(a), "readback");
      end
      $display("random readback done");
      id_hv = 1'b1;
      rd(FBM_OP_ID_READ, 18'h00000, q);
      chk(q, MAKER_ID, "maker");
      rd(FBM_OP_ID_READ, 18'h00001, q);
      chk(q, DEV_ID, "device");
      rd(FBM_OP_PROT_READ, 18'h38002, q);
      chk(q, 16'h0001, "prot set");
      rd(FBM_OP_PROT_READ, 18'h08002, q);
      chk(q, 16'h0000, "prot clear");
      id_hv = 1'b0;
      $display("identity done");
      a = 18'h38010;
      wr(a, 16'h1234);
      rd(FBM_OP_READ, a, q);
      chk(q, exp_rd(a), "protected");
      unprot_hv = 1'b1;
      wr(a, 16'h5678);
      chk(reset_hv, 1'b1, "hv pin");
      rd(FBM_OP_READ, a, q);
      chk(q, exp_rd(a), "unprotected");
      unprot_hv = 1'b0;
      wr(a, 16'h0F0F);
      rd(FBM_OP_READ, a, q);
      chk(q, exp_rd(a), "reprotected");
      $display("protection done");
      issue(FBM_OP_RESET, 18'h00000, 16'h0000);
      cnt = 0;
      repeat (40)
      begin
         @(negedge clk);
         if (reset_n === 1'b0)
            cnt++;
      end
      chk(cnt, `FBM_RST_HOLD_CYC, "reset width");
      a = 18'h00000;
      rd(FBM_OP_READ, a, q);
      chk(q, exp_rd(a), "after reset");
      chk(viol, 0, "recovery");
      a = 18'h00001;
      wr(a, 16'h3C5A);
      byte_mode = 1'b1;
      @(negedge clk);
      chk(byte_n, 1'b0, "byte strap");
      rd(FBM_OP_READ, a, q);
      e = exp_rd(a);
      chk(q, {8'h00, e[7:0]}, "byte read");
      chk(addr_low, a[0], "byte low address");
      byte_mode = 1'b0;
      $display("reset and strap done");
      report_and_stop();
   end
endmodule
